/* hdl/asd_pkg.sv */
// constants, field layouts and helpers shared by the scan command decoder
// assumes a single 100 MHz reference clock and an active-low asynchronous reset
package asd_pkg;

    // ----------------------------------------------------------------
    // command byte layout
    // ----------------------------------------------------------------
    localparam int unsigned CMD_W = 8;
    localparam int unsigned CONV_SEL_BIT = 7;
    localparam int unsigned SETUP_SEL_BIT = 6;
    // setup: clock mode 10 and select bit 6 set after reset, all other bits clear
    localparam logic [7:0] SETUP_RST = 8'h60;
    localparam logic [7:0] SCAN_CMD_RST = 8'h00;

    typedef struct packed {
        logic conv_sel;
        logic chan_sel_b3;
        logic chan_sel_b2;
        logic chan_sel_b1;
        logic chan_sel_b0;
        logic sweep_mode_hi;
        logic sweep_mode_lo;
        logic temp_req;
    } asd_scan_cmd_t;

    typedef struct packed {
        logic reg_sel_b7;
        logic reg_sel_b6;
        logic clk_mode_hi;
        logic clk_mode_lo;
        logic vref_mode_hi;
        logic vref_mode_lo;
        logic pair_cfg_hi;
        logic pair_cfg_lo;
    } asd_setup_t;

    // one request towards the conversion core
    typedef struct packed {
        logic [3:0] chan;
        logic pair;
        logic temp;
    } asd_conv_req_t;

    // ----------------------------------------------------------------
    // modes, channels and timing
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SWEEP_UP_TO = 2'h0, SWEEP_FROM = 2'h1, SWEEP_REPEAT = 2'h2, SWEEP_SINGLE = 2'h3
    } asd_sweep_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1, ST_PICK = 3'h2, ST_WAIT = 3'h4
    } asd_state_t;

    localparam logic [3:0] TOP_CHAN = 4'hf;
    localparam logic [3:0] VREF2_CHAN = 4'he;
    localparam logic [4:0] ONE_RESULT = 5'h01;
    localparam int unsigned REPEAT_SHIFT = 2;
    localparam logic [3:0] INT_CLK_DIV = 4'h8;
    localparam int unsigned REF_CLK_KHZ = 100000;
    localparam int unsigned SCLK_MAX_KHZ = 3600;
    localparam int unsigned SCLK_MIN_CYC = (REF_CLK_KHZ + SCLK_MAX_KHZ - 1) / SCLK_MAX_KHZ;
    localparam logic [5:0] SCLK_MIN_GAP = 6'(SCLK_MIN_CYC);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] asd_chan_of(input asd_scan_cmd_t c);
        return {c.chan_sel_b3, c.chan_sel_b2, c.chan_sel_b1, c.chan_sel_b0};
    endfunction

    function automatic asd_sweep_t asd_sweep_of(input asd_scan_cmd_t c);
        return asd_sweep_t'({c.sweep_mode_hi, c.sweep_mode_lo});
    endfunction

    // number of results of a repeated sweep: 4, 8, 12 or 16
    function automatic logic [4:0] asd_repeat_results(input logic [1:0] cnt);
        return 5'(({3'h0, cnt} + 5'h01) << REPEAT_SHIFT);
    endfunction

    // a channel (or its pair) shares a pin with the start input or second reference
    function automatic logic asd_chan_blocked(input logic [3:0] ch, input logic start_pin,
                                              input logic vref2_pin, input logic paired);
        logic [3:0] lo;
        logic [3:0] hi;
        lo = paired ? {ch[3:1], 1'b0} : ch;
        hi = paired ? {ch[3:1], 1'b1} : ch;
        return (start_pin && (lo == TOP_CHAN || hi == TOP_CHAN)) ||
               (vref2_pin && (lo == VREF2_CHAN || hi == VREF2_CHAN));
    endfunction

endpackage

/* hdl/asd_sync.sv */
// two-stage synchroniser for pins arriving from outside the clock domain
// assumes nothing downstream looks at the first stage
`timescale 1ns/1ps

module asd_sync #(
    parameter int unsigned WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // pins
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_r <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule // asd_sync

/* hdl/asd_rx.sv */
// serial byte receiver: msb first, framed by an active-low select
// assumes its inputs are already synchronised to ref_clk_i
`timescale 1ns/1ps

module asd_rx (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // synchronised serial pins
    input wire logic sclk_s_i,
    input wire logic cs_n_s_i,
    input wire logic din_s_i,
    // received byte
    output logic byte_valid_o,
    output logic [7:0] byte_o,
    output logic sclk_rise_o
);

    logic sclk_d_r;
    logic [2:0] cnt_r;
    logic [6:0] shift_r;
    wire rise = sclk_s_i & ~sclk_d_r;
    wire take = rise & ~cs_n_s_i;

    // shift on each rising edge; the eighth bit completes the byte
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_d_r <= 1'b0;
            cnt_r <= 3'h0;
            shift_r <= 7'h00;
            byte_valid_o <= 1'b0;
            byte_o <= 8'h00;
            sclk_rise_o <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s_i;
            sclk_rise_o <= rise;
            byte_valid_o <= take && cnt_r == 3'h7;
            if (cs_n_s_i) begin
                cnt_r <= 3'h0; // a partial byte dies with the frame
            end else if (take) begin
                cnt_r <= cnt_r + 3'h1;
                shift_r <= {shift_r[5:0], din_s_i};
                if (cnt_r == 3'h7) begin
                    byte_o <= {shift_r, din_s_i};
                end
            end
        end
    end

    // a byte only appears after eight edges inside one frame
    byte_eighth_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        byte_valid_o |-> $past(cnt_r) == 3'h7 && !$past(cs_n_s_i))
        else $error("byte completed without eight bits");

endmodule // asd_rx

/* hdl/asd_scan_decoder.sv */
// scan command decoder: receives command bytes, holds the scan and setup
// registers and walks the requested channel sequence towards the converter
// assumes the conversion core pulses conv_done_i once per request, same clock
`timescale 1ns/1ps

module asd_scan_decoder (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    input wire logic conv_start_n_i,
    // from neighbouring registers
    input wire logic repeat_count_hi_i,
    input wire logic repeat_count_lo_i,
    input wire logic [7:0] pair_mask_i,
    // conversion core
    input wire logic conv_done_i,
    output logic conv_req_o,
    output logic [3:0] conv_chan_o,
    output logic conv_pair_o,
    output logic conv_temp_o,
    output logic conv_clk_en_o,
    output logic acq_track_o,
    // status and configuration
    output logic scan_busy_o,
    output logic [1:0] clk_mode_o,
    output logic [1:0] vref_mode_o,
    output logic [1:0] pair_cfg_o,
    output logic top_is_start_o,
    output logic sclk_overspeed_o
);

    // ----------------------------------------------------------------
    // pin capture and byte receiver
    // ----------------------------------------------------------------
    logic [3:0] pins_s;
    logic byte_valid;
    logic [7:0] rx_byte;
    logic sclk_rise;

    // select and start idle high so no false edge leaves reset
    asd_sync #(.WIDTH(4), .RESET_VAL(4'h5)) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .async_i({sclk_i, cs_n_i, din_i, conv_start_n_i}),
        .sync_o(pins_s)
    );

    asd_rx u_rx (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .sclk_s_i(pins_s[3]),
        .cs_n_s_i(pins_s[2]),
        .din_s_i(pins_s[1]),
        .byte_valid_o(byte_valid),
        .byte_o(rx_byte),
        .sclk_rise_o(sclk_rise)
    );

    // ----------------------------------------------------------------
    // command decode and registers
    // ----------------------------------------------------------------
    asd_pkg::asd_scan_cmd_t scan_cmd_r;
    asd_pkg::asd_setup_t setup_r;
    asd_pkg::asd_scan_cmd_t job_r;
    logic setup_seen_r;
    logic start_n_d_r;
    asd_pkg::asd_state_t state_r;
    asd_pkg::asd_state_t state_nxt;

    // register select from the top bits of the byte
    wire is_conv = byte_valid && rx_byte[asd_pkg::CONV_SEL_BIT];
    wire is_setup = byte_valid && !rx_byte[asd_pkg::CONV_SEL_BIT] &&
                    rx_byte[asd_pkg::SETUP_SEL_BIT];
    wire [1:0] clk_mode = {setup_r.clk_mode_hi, setup_r.clk_mode_lo};
    wire start_pin_mode = !clk_mode[1];
    wire vref2_pin = setup_r.vref_mode_lo;
    wire start_fall = start_n_d_r && !pins_s[0];
    wire idle = state_r == asd_pkg::ST_IDLE;
    // a start while busy is dropped; the new command waits for the next start
    wire write_go = is_conv && clk_mode[1];
    wire pin_go = start_fall && start_pin_mode;
    wire go = idle && (write_go || pin_go);
    wire asd_pkg::asd_scan_cmd_t cmd_eff =
        is_conv ? asd_pkg::asd_scan_cmd_t'(rx_byte) : scan_cmd_r;

    // register writes; bytes for other registers are ignored here
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scan_cmd_r <= asd_pkg::SCAN_CMD_RST;
            setup_r <= asd_pkg::SETUP_RST;
            setup_seen_r <= 1'b0;
            start_n_d_r <= 1'b1;
        end else begin
            start_n_d_r <= pins_s[0];
            if (is_conv) begin
                scan_cmd_r <= asd_pkg::asd_scan_cmd_t'(rx_byte);
            end
            if (is_setup) begin
                setup_r <= asd_pkg::asd_setup_t'(rx_byte);
                setup_seen_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // sweep sequencer
    // ----------------------------------------------------------------
    logic [3:0] cur_r;
    logic [3:0] last_r;
    logic [4:0] reps_r;
    logic temp_pend_r;
    logic wait_temp_r;

    // start point, end point and count of the new sweep
    wire [3:0] n_chan = asd_pkg::asd_chan_of(cmd_eff);
    wire asd_pkg::asd_sweep_t n_sweep = asd_pkg::asd_sweep_of(cmd_eff);
    wire n_paired = pair_mask_i[n_chan[3:1]];
    wire [3:0] n_norm = n_paired ? {n_chan[3:1], 1'b0} : n_chan;
    wire [3:0] go_cur = (n_sweep == asd_pkg::SWEEP_UP_TO) ? 4'h0 : n_norm;
    wire [3:0] go_last = (n_sweep == asd_pkg::SWEEP_UP_TO) ? n_chan :
                         (n_sweep == asd_pkg::SWEEP_FROM) ? asd_pkg::TOP_CHAN : n_norm;
    wire [4:0] go_reps = (n_sweep == asd_pkg::SWEEP_REPEAT) ?
        asd_pkg::asd_repeat_results({repeat_count_hi_i, repeat_count_lo_i}) :
        asd_pkg::ONE_RESULT;

    // per-channel decision while walking
    wire asd_pkg::asd_sweep_t job_sweep = asd_pkg::asd_sweep_of(job_r);
    wire walk = job_sweep == asd_pkg::SWEEP_UP_TO || job_sweep == asd_pkg::SWEEP_FROM;
    wire cur_paired = pair_mask_i[cur_r[3:1]];
    wire cur_blocked = asd_pkg::asd_chan_blocked(cur_r, start_pin_mode, vref2_pin,
                                                 cur_paired);
    wire emit = !cur_blocked && !(cur_paired && cur_r[0]);
    wire at_end = walk ? (cur_r == last_r) : (reps_r == asd_pkg::ONE_RESULT);
    wire in_pick = state_r == asd_pkg::ST_PICK;
    wire in_wait = state_r == asd_pkg::ST_WAIT;
    wire issue = in_pick && (temp_pend_r || emit);
    wire step = (in_pick && !temp_pend_r && !emit) ||
                (in_wait && conv_done_i && !wait_temp_r);

    // next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            asd_pkg::ST_IDLE: begin
                if (go) begin
                    state_nxt = asd_pkg::ST_PICK;
                end
            end
            asd_pkg::ST_PICK: begin
                if (issue) begin
                    state_nxt = asd_pkg::ST_WAIT;
                end else if (at_end) begin
                    state_nxt = asd_pkg::ST_IDLE;
                end
            end
            asd_pkg::ST_WAIT: begin
                if (conv_done_i) begin
                    state_nxt = (wait_temp_r || !at_end) ? asd_pkg::ST_PICK : asd_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = asd_pkg::ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= asd_pkg::ST_IDLE;
            job_r <= asd_pkg::SCAN_CMD_RST;
            cur_r <= 4'h0;
            last_r <= 4'h0;
            reps_r <= asd_pkg::ONE_RESULT;
            temp_pend_r <= 1'b0;
            wait_temp_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (go) begin
                job_r <= cmd_eff;
                cur_r <= go_cur;
                last_r <= go_last;
                reps_r <= go_reps;
                temp_pend_r <= cmd_eff.temp_req; // temperature goes ahead
            end else if (step && !at_end) begin
                cur_r <= walk ? cur_r + 4'h1 : cur_r;
                reps_r <= reps_r - 5'h01;
            end
            if (issue) begin
                wait_temp_r <= temp_pend_r;
                temp_pend_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // conversion clock, acquisition and serial-clock watch
    // ----------------------------------------------------------------
    logic [3:0] div_r;
    logic [5:0] gap_r;
    logic gap_armed_r;
    wire div_tick = div_r == asd_pkg::INT_CLK_DIV - 4'h1;
    wire ext_clk = clk_mode == 2'h3;
    // a too-short gap between serial edges in external clock mode
    wire too_fast = ext_clk && sclk_rise && !pins_s[2] && gap_armed_r &&
                    gap_r < asd_pkg::SCLK_MIN_GAP;

    // divider keeps running so the internal clock never needs a restart
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_r <= 4'h0;
            gap_r <= 6'h00;
            gap_armed_r <= 1'b0;
        end else begin
            div_r <= div_tick ? 4'h0 : div_r + 4'h1;
            if (sclk_rise) begin
                gap_r <= 6'h00;
            end else if (gap_r != asd_pkg::SCLK_MIN_GAP) begin
                gap_r <= gap_r + 6'h01;
            end
            gap_armed_r <= pins_s[2] ? 1'b0 : (gap_armed_r || sclk_rise);
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            conv_req_o <= 1'b0;
            conv_chan_o <= 4'h0;
            conv_pair_o <= 1'b0;
            conv_temp_o <= 1'b0;
            conv_clk_en_o <= 1'b0;
            acq_track_o <= 1'b0;
            scan_busy_o <= 1'b0;
            top_is_start_o <= ~asd_pkg::SETUP_RST[5]; // role follows reset clock mode
            sclk_overspeed_o <= 1'b0;
        end else begin
            conv_req_o <= issue;
            if (issue) begin
                conv_chan_o <= temp_pend_r ? 4'h0 : cur_r;
                conv_pair_o <= !temp_pend_r && cur_paired;
                conv_temp_o <= temp_pend_r;
            end
            conv_clk_en_o <= ext_clk ? sclk_rise : (div_tick && !ext_clk);
            acq_track_o <= (clk_mode == 2'h1) ? !pins_s[0] : 1'b0;
            scan_busy_o <= state_nxt != asd_pkg::ST_IDLE;
            top_is_start_o <= start_pin_mode;
            // set wins over the clear of a setup write
            sclk_overspeed_o <= too_fast || (sclk_overspeed_o && !is_setup);
        end
    end

    assign clk_mode_o = clk_mode;
    assign vref_mode_o = {setup_r.vref_mode_hi, setup_r.vref_mode_lo};
    assign pair_cfg_o = {setup_r.pair_cfg_hi, setup_r.pair_cfg_lo};

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_idle_start;
        idle && go;
    endsequence

    conv_write_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        is_conv |=> scan_cmd_r == $past(rx_byte))
        else $error("scan command not written");

    setup_write_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        byte_valid && !rx_byte[7] |=> setup_r == $past(is_setup ? rx_byte : setup_r))
        else $error("setup written by wrong byte");

    setup_reset_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        !setup_seen_r |-> setup_r.clk_mode_hi && setup_r == asd_pkg::SETUP_RST)
        else $error("clock mode upper bit lost before any setup write");

    write_start_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        idle && is_conv && clk_mode[1] |=> scan_busy_o ##0 job_r == $past(rx_byte))
        else $error("scan command write did not start the scan");

    pin_start_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        idle && start_fall && !clk_mode[1] |=> scan_busy_o)
        else $error("start pulse did not start the scan");

    no_pin_start_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        idle && !is_conv && clk_mode[1] |=> !scan_busy_o)
        else $error("scan started without a command write");

    temp_first_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        s_idle_start and cmd_eff.temp_req |=> issue ##1 conv_req_o && conv_temp_o)
        else $error("temperature was not the first result");

    skip_blocked_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        issue && !temp_pend_r |-> !asd_pkg::asd_chan_blocked(cur_r, start_pin_mode,
                                                             vref2_pin, cur_paired))
        else $error("blocked channel converted");

    pair_even_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        conv_req_o && conv_pair_o |-> !conv_chan_o[0])
        else $error("pair converted on odd channel");

    upto_range_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        issue && !temp_pend_r && job_sweep == asd_pkg::SWEEP_UP_TO
        |-> cur_r <= asd_pkg::asd_chan_of(job_r))
        else $error("sweep up-to went past N");

    from_range_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        issue && !temp_pend_r && job_sweep == asd_pkg::SWEEP_FROM
        |-> cur_r >= {job_r.chan_sel_b3, job_r.chan_sel_b2, job_r.chan_sel_b1, 1'b0})
        else $error("sweep from-N started below N");

    single_chan_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        issue && !temp_pend_r && job_sweep == asd_pkg::SWEEP_SINGLE
        |-> cur_r[3:1] == asd_pkg::asd_chan_of(job_r) >> 1 ##1 conv_chan_o == $past(cur_r))
        else $error("single conversion on wrong channel");

    pin_role_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        $changed(clk_mode[1]) |=> top_is_start_o == !clk_mode[1])
        else $error("shared pin role does not follow clock mode");

endmodule // asd_scan_decoder

/* verif/asd_host_model.sv */
// host side of the serial port: shifts command bytes into the decoder
// assumes each byte is started just after a falling ref clock edge
`timescale 1ns/1ps

module asd_host_model (
    // serial pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o
);
    // idle: clock low, select high
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b0;
    end
    // half period of sclk; a test may shorten it on purpose to trip the speed watch
    int half_ns = 150;
    // 300 ns period keeps sclk near 3.3 MHz, legal in clock mode 11
    task automatic send_byte(input logic [7:0] b);
        cs_n_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin // msb first
            din_o = b[i];
            #half_ns sclk_o = 1'b1;
            #half_ns sclk_o = 1'b0;
        end
        din_o = ~din_o; // released line must not show a stale bit
        #150 cs_n_o = 1'b1;
        #150; // select stays high between bytes so each frame is closed
    endtask
endmodule // asd_host_model

/* verif/tb_top.sv */
// self-checking bench for the scan command decoder
// assumes the host model and an instant-answer stand-in for the conversion core
`timescale 1ns/1ps

module tb_top;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic conv_start_n_i = 1'b1;
    logic repeat_count_hi_i = 1'b0;
    logic repeat_count_lo_i = 1'b0;
    logic [7:0] pair_mask_i = 8'h00;
    logic conv_done_i = 1'b0;
    logic sclk, cs_n, din, conv_req_o, conv_pair_o, conv_temp_o, conv_clk_en_o;
    logic acq_track_o, scan_busy_o, top_is_start_o, sclk_overspeed_o;
    logic [3:0] conv_chan_o;
    logic [1:0] clk_mode_o, vref_mode_o, pair_cfg_o;
    logic [5:0] got_q[$];
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    int en_cnt = 0;
    int en_base = 0;
    logic acq_exp = 1'b0;

    always #5 ref_clk_i = ~ref_clk_i;

    asd_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
    asd_scan_decoder uut (.ref_clk_i, .reset_n_i, .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
        .conv_start_n_i, .repeat_count_hi_i, .repeat_count_lo_i, .pair_mask_i, .conv_done_i,
        .conv_req_o, .conv_chan_o, .conv_pair_o, .conv_temp_o, .conv_clk_en_o, .acq_track_o,
        .scan_busy_o, .clk_mode_o, .vref_mode_o, .pair_cfg_o, .top_is_start_o,
        .sclk_overspeed_o);

    // core stand-in: log each request, answer it one cycle later, count clock enables
    always @(negedge ref_clk_i) begin
        conv_done_i <= (conv_req_o === 1'b1);
        if (conv_clk_en_o === 1'b1)
            en_cnt <= en_cnt + 1;
        if (conv_req_o === 1'b1)
            got_q.push_back({conv_temp_o, conv_pair_o, conv_chan_o});
    end
    // hang guard, well above the ~3600 cycles the run needs
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // send one scan command, optionally fire the start pin, compare requests
    task automatic scan(input logic [7:0] b, input logic pin, input logic [5:0] e[$]);
        int n;
        n = 0;
        u_host.send_byte(b);
        if (pin) begin
            chk({7'h0, scan_busy_o}, 8'h00);
            conv_start_n_i = 1'b0;
            repeat (4) @(negedge ref_clk_i);
            chk({7'h0, acq_track_o}, {7'h0, acq_exp});
            conv_start_n_i = 1'b1;
            repeat (8) @(negedge ref_clk_i);
            chk({7'h0, acq_track_o}, 8'h00);
        end
        while (scan_busy_o !== 1'b0 && n < 3000) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk(8'(got_q.size()), 8'(e.size()));
        foreach (e[i]) chk({2'h0, got_q[i]}, {2'h0, e[i]});
        got_q.delete();
    endtask

    // main sequence: setup fields first, then every sweep mode
    initial begin
        repeat (20) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        chk({6'h0, clk_mode_o}, 8'h02);
        chk({7'h0, top_is_start_o}, 8'h00);
        en_base = en_cnt;
        repeat (80) @(negedge ref_clk_i);
        chk(8'(en_cnt - en_base), 8'(80 / asd_pkg::INT_CLK_DIV));
        u_host.send_byte(8'h6d);
        chk({2'h0, clk_mode_o, vref_mode_o, pair_cfg_o}, 8'h2d);
        chk({7'h0, top_is_start_o}, 8'h00);
        u_host.send_byte(8'h3f);
        chk({2'h0, clk_mode_o, vref_mode_o, pair_cfg_o}, 8'h2d);
        scan(8'haf, 1'b0, '{6'h20, 6'h05});
        pair_mask_i = 8'h01;
        scan(8'h98, 1'b0, '{6'h10, 6'h02, 6'h03});
        pair_mask_i = 8'h00;
        scan(8'he2, 1'b0, '{6'h0c, 6'h0d, 6'h0f});
        repeat_count_lo_i = 1'b1;
        scan(8'h94, 1'b0, '{6'h02, 6'h02, 6'h02, 6'h02, 6'h02, 6'h02, 6'h02, 6'h02});
        u_host.send_byte(8'h7c);
        en_base = en_cnt;
        scan(8'h8e, 1'b0, '{6'h01});
        chk(8'(en_cnt - en_base), 8'h08);
        chk({7'h0, sclk_overspeed_o}, 8'h00);
        u_host.half_ns = 100;
        u_host.send_byte(8'h3f);
        u_host.half_ns = 150;
        chk({7'h0, sclk_overspeed_o}, 8'h01);
        u_host.send_byte(8'h40);
        chk({7'h0, sclk_overspeed_o}, 8'h00);
        chk({7'h0, top_is_start_o}, 8'h01);
        scan(8'hf2, 1'b1, '{6'h0e});
        u_host.send_byte(8'h50);
        acq_exp = 1'b1;
        scan(8'hbf, 1'b1, '{6'h20, 6'h07});
        reset_n_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        chk({2'h0, clk_mode_o, vref_mode_o, pair_cfg_o}, 8'h20);
        chk({7'h0, top_is_start_o}, 8'h00);
        final_report();
    end
endmodule // tb_top
